// >>> hdl/tpc_counter.sv
// Tracking position counter with busy, carry, direction and output latches
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/10ps

// Behaviour
// [RULE_01] Two select inputs set position width to 10, 12, 14 or 16 bits.
// [RULE_02] Resolution changes while moving should be made only while busy is low.
// [RULE_03] No convert command; counter steps by one LSB per input angle step.
// [RULE_04] Every counter increment or decrement gives one busy pulse.
// [RULE_05] Position is unsigned binary; all zeros and all ones bound one revolution.
// [RULE_06] Carry pulse on wrap from all ones to zeros or zeros to ones.
// [RULE_07] Direction output is valid before the matching carry pulse begins.
// [RULE_08] Direction is latched and changes only on a real reversal step.
// [RULE_09] Carry and direction keep working while the latches are frozen.
// [RULE_10] Freeze low stops latch updates; release gives a refreshing busy pulse.
// [RULE_11] Data pins undriven while enable is high, latched word driven while low.
// [RULE_12] Byte choice high gives MS byte on first byte, else LS byte duplicate.
// [RULE_13] Counter is modulo two to the selected width, wrapping both ways.
// [RULE_14] One step per internal step pulse, signed by the direction latch.
module tpc_counter
(
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Internal step source
   input wire logic step_req,
   input wire logic step_up,
   // Resolution and latch control
   input wire logic resolution_select_low,
   input wire logic resolution_select_high,
   input wire logic freeze_n,
   input wire logic output_enable_n,
   input wire logic byte_select_high,
   // Position status outputs
   output logic busy,
   output logic rev_carry,
   output logic rot_dir,
   // Parallel data bus pins
   output logic [tpc_pkg::POS_W-1:0] position_data_lines_o,
   output logic [tpc_pkg::POS_W-1:0] position_data_lines_oe,
   // Register port
   input wire logic [tpc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Interrupt
   output logic irq
);
   import tpc_pkg::*;

   typedef struct packed {
      logic [POS_W-1:0] cnt_q;
      logic dir_q;
      logic pend_q;
      logic pend_up_q;
      logic busy_q;
      logic carry_q;
      logic [CARRY_CNT_W-1:0] carry_cnt_q;
      logic [POS_W-1:0] latch_q;
      logic frz_prev_q;
      logic [POS_W-1:0] data_q;
      logic [POS_W-1:0] oe_q;
      logic track_en_q;
      logic [EVT_W-1:0] status_q;
      logic [EVT_W-1:0] mask_q;
      logic irq_q;
      logic [31:0] rdata_q;
   } tpc_state_t;

   localparam tpc_state_t ST_RESET = '{
      cnt_q: '0,
      dir_q: 1'b1,
      pend_q: 1'b0,
      pend_up_q: 1'b1,
      busy_q: 1'b0,
      carry_q: 1'b0,
      carry_cnt_q: '0,
      latch_q: '0,
      frz_prev_q: 1'b1,
      data_q: '0,
      oe_q: '0,
      track_en_q: CTRL_RESET,
      status_q: STATUS_RESET,
      mask_q: MASK_RESET,
      irq_q: 1'b0,
      rdata_q: '0
   };

   tpc_state_t st;
   tpc_state_t st_d;

   logic [POS_W-1:0] res_mask;
   logic [4:0] res_shift;
   logic [1:0] res_sel;

   assign res_sel = {resolution_select_high, resolution_select_low};

   // Width follows the pins live; the host keeps changes to idle gaps (see [RULE_02])
   always_comb
   begin
      unique case (res_sel) // see [RULE_01]
         RES_SEL_10:
         begin
            res_mask = RES_MASK_10;
            res_shift = RES_SHIFT_10;
         end
         RES_SEL_12:
         begin
            res_mask = RES_MASK_12;
            res_shift = RES_SHIFT_12;
         end
         RES_SEL_14:
         begin
            res_mask = RES_MASK_14;
            res_shift = RES_SHIFT_14;
         end
         RES_SEL_16:
         begin
            res_mask = RES_MASK_16;
            res_shift = RES_SHIFT_16;
         end
      endcase
   end

   always_comb
   begin
      logic [POS_W-1:0] cnt_next;
      logic [POS_W-1:0] cnt_cur;
      logic wrap;
      logic refresh;
      logic [EVT_W-1:0] evt;
      logic [EVT_W-1:0] clr;
      cnt_next = '0;
      cnt_cur = '0;
      wrap = 1'b0;
      refresh = 1'b0;
      evt = '0;
      clr = '0;
      st_d = st;

      // Step requests latch the sign one cycle ahead of the count,
      // so direction is settled before busy, data or carry move
      st_d.pend_q = step_req & st.track_en_q; // see [RULE_03]
      if (step_req && st.track_en_q)
      begin
         st_d.pend_up_q = step_up;
         st_d.dir_q = step_up; // see [RULE_07] see [RULE_08]
         evt[EVT_REV_BIT] = step_up != st.dir_q;
      end

      cnt_cur = st.cnt_q & res_mask;
      st_d.busy_q = 1'b0;
      if (st.pend_q)
      begin
         // Modulo count in the selected width, no saturation
         if (st.pend_up_q) // see [RULE_14]
         begin
            cnt_next = (cnt_cur + 16'h0001) & res_mask; // see [RULE_13]
            wrap = cnt_cur == res_mask;
         end
         else
         begin
            cnt_next = (cnt_cur - 16'h0001) & res_mask; // see [RULE_13]
            wrap = cnt_cur == 16'h0000;
         end
         st_d.cnt_q = cnt_next; // see [RULE_05]
         st_d.busy_q = 1'b1; // see [RULE_04]
         evt[EVT_STEP_BIT] = 1'b1;
      end
      else
      begin
         cnt_next = cnt_cur;
         st_d.cnt_q = cnt_cur;
      end

      // Carry ignores the freeze input entirely
      if (wrap) // see [RULE_06] see [RULE_09]
      begin
         st_d.carry_q = 1'b1;
         st_d.carry_cnt_q = CARRY_CNT_W'(CARRY_CYC - 1);
         evt[EVT_CARRY_BIT] = 1'b1;
      end
      else if (st.carry_cnt_q != '0)
      begin
         st_d.carry_cnt_q = st.carry_cnt_q - 7'h01;
      end
      else
      begin
         st_d.carry_q = 1'b0;
      end

      // Latches: follow each step while free, refresh on release
      st_d.frz_prev_q = freeze_n;
      refresh = freeze_n & ~st.frz_prev_q;
      if (refresh)
      begin
         st_d.busy_q = 1'b1; // see [RULE_10]
      end
      if (freeze_n && (st.pend_q || refresh))
      begin
         // Left aligned so unused low lines read low
         st_d.latch_q = cnt_next << res_shift; // see [RULE_10] see [RULE_12]
      end

      // Pin drivers
      st_d.oe_q = {POS_W{~output_enable_n}}; // see [RULE_11]
      st_d.data_q[BYTE_W-1:0] = st.latch_q[BYTE_W-1:0];
      st_d.data_q[POS_W-1:BYTE_W] = byte_select_high ? st.latch_q[POS_W-1:BYTE_W]
                                                     : st.latch_q[BYTE_W-1:0]; // see [RULE_12]

      // Register writes; a new event beats its own clear
      if (reg_wr)
      begin
         unique case (reg_addr)
            REG_CTRL: st_d.track_en_q = reg_wdata[CTRL_TRACK_BIT];
            REG_STATUS: clr = reg_wdata[EVT_W-1:0];
            REG_MASK: st_d.mask_q = reg_wdata[EVT_W-1:0];
            default: ;
         endcase
      end
      st_d.status_q = (st.status_q & ~clr) | evt;
      st_d.irq_q = |(st_d.status_q & st_d.mask_q);

      // Read data stands for one cycle only
      st_d.rdata_q = '0;
      if (reg_rd)
      begin
         unique case (reg_addr)
            REG_CTRL: st_d.rdata_q[CTRL_TRACK_BIT] = st.track_en_q;
            REG_STATUS: st_d.rdata_q[EVT_W-1:0] = st.status_q;
            REG_MASK: st_d.rdata_q[EVT_W-1:0] = st.mask_q;
            REG_POS: st_d.rdata_q[POS_W-1:0] = cnt_cur;
            REG_INFO:
            begin
               st_d.rdata_q[INFO_SEL_LSB+1:INFO_SEL_LSB] = res_sel;
               st_d.rdata_q[INFO_BUSY_BIT] = st.busy_q;
               st_d.rdata_q[INFO_CARRY_BIT] = st.carry_q;
               st_d.rdata_q[INFO_DIR_BIT] = st.dir_q;
               st_d.rdata_q[INFO_FREEZE_BIT] = freeze_n;
            end
            default: st_d.rdata_q = '0;
         endcase
      end
   end

   // Clock enable low holds every flop, including pin drivers
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         st <= ST_RESET;
      end
      else if (clk_en)
      begin
         st <= st_d;
      end
   end

   assign busy = st.busy_q;
   assign rev_carry = st.carry_q;
   assign rot_dir = st.dir_q;
   assign position_data_lines_o = st.data_q;
   assign position_data_lines_oe = st.oe_q;
   assign reg_rdata = st.rdata_q;
   assign irq = st.irq_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   busy_per_step_a: // see [RULE_04]
   assert property (clk_en && st.pend_q |=> st.busy_q)
   else $error("step without busy pulse");

   count_modulo_a: // see [RULE_13]
   assert property (clk_en && st.pend_q && st.pend_up_q && $stable(res_sel)
                    |=> st.cnt_q == (($past(st.cnt_q) + 16'h0001) & $past(res_mask)))
   else $error("counter did not increment modulo width");

   carry_on_wrap_a: // see [RULE_06]
   assert property (clk_en && st.pend_q && !st.pend_up_q && (st.cnt_q & res_mask) == 16'h0000
                    |=> st.carry_q && st.cnt_q == $past(res_mask))
   else $error("down wrap without carry");

   carry_width_a: // see [RULE_06]
   assert property ($rose(st.carry_q) && clk_en |=> st.carry_q [*8])
   else $error("carry pulse too short");

   dir_before_carry_a: // see [RULE_07]
   assert property ($rose(st.carry_q) |-> $stable(st.dir_q) || !$past(clk_en))
   else $error("direction moved with carry");

   dir_only_on_step_a: // see [RULE_08]
   assert property (!(step_req && st.track_en_q) && clk_en |=> $stable(st.dir_q))
   else $error("direction changed without step");

   freeze_hold_a: // see [RULE_10]
   assert property (clk_en && !freeze_n |=> $stable(st.latch_q))
   else $error("latch moved while frozen");

   release_busy_a: // see [RULE_10]
   assert property (clk_en && freeze_n && !st.frz_prev_q
                    |=> st.busy_q && st.latch_q == (st.cnt_q << $past(res_shift)))
   else $error("release did not refresh latch");

   pin_enable_a: // see [RULE_11]
   assert property (clk_en |=> st.oe_q == {POS_W{~$past(output_enable_n)}})
   else $error("data pin enable wrong");

   byte_dup_a: // see [RULE_12]
   assert property (clk_en && !byte_select_high
                    |=> st.data_q[POS_W-1:BYTE_W] == st.data_q[BYTE_W-1:0])
   else $error("low byte not duplicated");

   unused_low_a: // see [RULE_12]
   assert property (clk_en && res_sel == RES_SEL_10 && $stable(res_sel) && st.pend_q && freeze_n
                    |=> st.latch_q[5:0] == 6'h00)
   else $error("unused low lines not low");
endmodule

// >>> hdl/tpc_pkg.sv
// Constants shared by the tracking position counter block
package tpc_pkg;
   // Core clock period in picoseconds (250 MHz)
   localparam int CLK_PERIOD_PS = 4000;
   // Least revolution carry pulse width
   localparam int CARRY_MIN_NS = 300;
   localparam int CARRY_CYC = (CARRY_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CARRY_CNT_W = 7;

   // Position word
   localparam int POS_W = 16;
   localparam int BYTE_W = 8;

   // Resolution select codes {high, low} with masks and left-align shifts
   localparam logic [1:0] RES_SEL_10 = 2'h0;
   localparam logic [1:0] RES_SEL_12 = 2'h1;
   localparam logic [1:0] RES_SEL_14 = 2'h2;
   localparam logic [1:0] RES_SEL_16 = 2'h3;
   localparam logic [15:0] RES_MASK_10 = 16'h03FF;
   localparam logic [15:0] RES_MASK_12 = 16'h0FFF;
   localparam logic [15:0] RES_MASK_14 = 16'h3FFF;
   localparam logic [15:0] RES_MASK_16 = 16'hFFFF;
   localparam logic [4:0] RES_SHIFT_10 = 5'h06;
   localparam logic [4:0] RES_SHIFT_12 = 5'h04;
   localparam logic [4:0] RES_SHIFT_14 = 5'h02;
   localparam logic [4:0] RES_SHIFT_16 = 5'h00;

   // Register map (byte addresses)
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_MASK = 8'h08;
   localparam logic [7:0] REG_POS = 8'h0C;
   localparam logic [7:0] REG_INFO = 8'h10;

   // Control field: tracking enable
   localparam int CTRL_TRACK_BIT = 0;
   localparam logic CTRL_RESET = 1'b1;

   // Event bits of status and mask
   localparam int EVT_W = 3;
   localparam int EVT_STEP_BIT = 0;
   localparam int EVT_CARRY_BIT = 1;
   localparam int EVT_REV_BIT = 2;
   localparam logic [2:0] STATUS_RESET = 3'h0;
   localparam logic [2:0] MASK_RESET = 3'h0;

   // Info register fields
   localparam int INFO_SEL_LSB = 0;
   localparam int INFO_BUSY_BIT = 2;
   localparam int INFO_CARRY_BIT = 3;
   localparam int INFO_DIR_BIT = 4;
   localparam int INFO_FREEZE_BIT = 5;
endpackage

// >>> tb/tpc_host_model.sv
// Host data bus and external revolution counter beside the position counter
`timescale 1ns/10ps
module tpc_host_model
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Pins seen from the host
   input wire logic [15:0] lines_o,
   input wire logic [15:0] lines_oe,
   input wire logic rev_carry,
   input wire logic rot_dir,
   // Resolved bus and revolution count
   output logic [15:0] bus_v,
   output logic signed [15:0] rev_count
);
   logic [15:0] last_q;
   logic carry_q;
   // An undriven line shows the inverse of the level last driven on it, so stale data never matches
   assign bus_v = (lines_o & lines_oe) | (~last_q & ~lines_oe);
   always_ff @(posedge core_clk)
   begin
      carry_q <= rev_carry;
      if (rst)
      begin
         last_q <= 16'h0000;
         rev_count <= 16'sh0000;
      end
      else
      begin
         last_q <= (lines_o & lines_oe) | (last_q & ~lines_oe);
         if (rev_carry && !carry_q)
         begin
            // Direction picks the count sense at the carry edge
            rev_count <= rot_dir ? rev_count + 16'sh0001 : rev_count - 16'sh0001;
         end
      end
   end
endmodule

// >>> tb/tpc_counter_tb.sv
// Self-checking bench for the tracking position counter
`timescale 1ns/10ps
module tpc_counter_tb;
   import tpc_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic step_req = 1'b0, step_up = 1'b1, sel_lo = 1'b0, sel_hi = 1'b0;
   logic freeze_n = 1'b1, oe_n = 1'b0, byte_hi = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic clk_en = 1'b1;
   int carry_run = 0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, rdata, reg_rdata;
   logic busy, rev_carry, rot_dir, irq;
   logic [15:0] lines_o, lines_oe, bus_v, exp_w;
   logic signed [15:0] rev_count;
   logic [15:0] masks [4] = '{RES_MASK_10, RES_MASK_12, RES_MASK_14, RES_MASK_16};
   logic [4:0] shifts [4] = '{RES_SHIFT_10, RES_SHIFT_12, RES_SHIFT_14, RES_SHIFT_16};
   int errors = 0, samples_checked = 0;
   always #2 core_clk = ~core_clk;
   // Length of the current carry pulse in cycles, zero while it is low
   always @(posedge core_clk)
      carry_run <= (rev_carry === 1'b1) ? carry_run + 1 : 0;
   tpc_counter uut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .step_req(step_req),
      .step_up(step_up), .resolution_select_low(sel_lo), .resolution_select_high(sel_hi),
      .freeze_n(freeze_n), .output_enable_n(oe_n), .byte_select_high(byte_hi), .busy(busy),
      .rev_carry(rev_carry), .rot_dir(rot_dir), .position_data_lines_o(lines_o),
      .position_data_lines_oe(lines_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   tpc_host_model host (.core_clk(core_clk), .rst(rst), .lines_o(lines_o),
      .lines_oe(lines_oe), .rev_carry(rev_carry), .rot_dir(rot_dir), .bus_v(bus_v),
      .rev_count(rev_count));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rdata = reg_rdata;
   endtask
   // Busy stands for one cycle, one edge after the request is taken
   task automatic step(input logic up);
      @(posedge core_clk);
      step_req <= 1'b1;
      step_up <= up;
      @(posedge core_clk);
      step_req <= 1'b0;
      tick(1);
      check(busy, 1'b1);
   endtask
   // Carry must stand at least 300 ns, then drop so the next wrap gives a fresh edge
   task automatic carry_done();
      int n;
      n = 0;
      while (rev_carry !== 1'b0 && n < CARRY_CYC + 8)
      begin
         tick(1);
         n++;
      end
      if (rev_carry !== 1'b0)
      begin
         errors++;
         $display("BAD %0t carry never dropped", $time);
         finish_test();
      end
      check(carry_run >= CARRY_CYC, 1'b1);
   endtask
   task automatic test_reset();
      check({busy, rev_carry, rot_dir, irq}, 4'h2);
      reg_read(REG_CTRL);
      check(rdata, 32'h1);
      reg_read(REG_STATUS);
      check(rdata, 32'h0);
      reg_read(REG_MASK);
      check(rdata, 32'h0);
      reg_read(REG_INFO);
      check(rdata, (32'h1 << INFO_DIR_BIT) | (32'h1 << INFO_FREEZE_BIT));
      reg_read(8'h14);
      check(rdata, 32'h0);
      $display("test reset done");
   endtask
   task automatic test_resolution();
      for (int r = 0; r < 4; r++)
      begin
         @(posedge core_clk);
         {sel_hi, sel_lo} <= r[1:0];
         exp_w = masks[r] << shifts[r];
         step(1'b0);
         check(rev_carry, 1'b1);
         check(rot_dir, 1'b0);
         tick(1);
         check(busy, 1'b0);
         tick(2);
         check(bus_v, exp_w);
         check({16'h0, rev_count}, 32'h0000FFFF);
         reg_read(REG_POS);
         check(rdata, {16'h0, masks[r]});
         @(posedge core_clk);
         byte_hi <= 1'b0;
         tick(2);
         check(bus_v, {exp_w[7:0], exp_w[7:0]});
         @(posedge core_clk);
         byte_hi <= 1'b1;
         carry_done();
         step(1'b1);
         check({rev_carry, rot_dir}, 2'h3);
         reg_read(REG_POS);
         check(rdata, 32'h0);
         carry_done();
         check({16'h0, rev_count}, 32'h0);
      end
      $display("test resolution done");
   endtask
   task automatic test_irq();
      reg_read(REG_STATUS);
      check(rdata, 32'h7);
      reg_write(REG_MASK, 32'h1 << EVT_CARRY_BIT);
      tick(2);
      check(irq, 1'b1);
      reg_write(REG_STATUS, 32'h7);
      reg_read(REG_STATUS);
      check(rdata, 32'h0);
      check(irq, 1'b0);
      $display("test irq done");
   endtask
   task automatic test_freeze();
      @(posedge core_clk);
      freeze_n <= 1'b0;
      step(1'b0);
      check({rev_carry, rot_dir}, 2'h2);
      tick(3);
      check(bus_v, 16'h0000);
      @(posedge core_clk);
      freeze_n <= 1'b1;
      tick(1);
      check(busy, 1'b1);
      tick(2);
      check(bus_v, 16'hFFFF);
      @(posedge core_clk);
      oe_n <= 1'b1;
      tick(1);
      check(lines_oe, 16'h0000);
      check(bus_v, 16'h0000);
      @(posedge core_clk);
      oe_n <= 1'b0;
      carry_done();
      step(1'b1);
      carry_done();
      $display("test freeze done");
   endtask
   // A low clock enable must hold every flop, even with a step pending
   task automatic test_enable();
      @(posedge core_clk);
      clk_en <= 1'b0;
      step_req <= 1'b1;
      step_up <= 1'b0;
      tick(4);
      check({busy, rot_dir}, 2'h1);
      @(posedge core_clk);
      clk_en <= 1'b1;
      step_req <= 1'b0;
      reg_read(REG_POS);
      check(rdata, 32'h0);
      $display("test enable done");
   endtask
   task automatic test_refuse();
      reg_write(REG_CTRL, 32'h0);
      @(posedge core_clk);
      step_req <= 1'b1;
      step_up <= 1'b0;
      @(posedge core_clk);
      step_req <= 1'b0;
      tick(1);
      check(busy, 1'b0);
      check(rot_dir, 1'b1);
      reg_read(REG_POS);
      check(rdata, 32'h0);
      reg_write(REG_CTRL, 32'h1);
      $display("test refuse done");
   endtask
   initial
   begin
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      tick(1);
      test_reset();
      test_resolution();
      test_irq();
      test_freeze();
      test_enable();
      test_refuse();
      finish_test();
   end
endmodule
